// ==== common/reset_pin_pkg.sv ====
// Purpose: shared constants and types for the reset pin state control block
// Assumes: mclk at 10 MHz
// Notes: blink count exceeds 4096 cycles, so the top exposes it as a parameter
package reset_pin_pkg;
  localparam int MCLK_HZ = 10_000_000;
  localparam int BLINK_HZ = 1;
  // half a blink period, in mclk cycles
  localparam int BLINK_HALF_CYCLES = MCLK_HZ / (2 * BLINK_HZ);
  localparam int BLINK_CNT_W = 23;

  // open-drain pins only ever drive this level
  localparam logic OD_DRIVE_LEVEL = 1'h0;
  // values held while reset is applied
  localparam logic PG_OE_RST = 1'h1;
  localparam logic GP_OE_RST = 1'h1;
  localparam logic BLINK_RST = 1'h1;
  localparam logic RESUME_READY_RST = 1'h0;
  localparam logic SYNC_RST = 1'h0;

  typedef enum logic {BOOT_HOLD, BOOT_RUN} boot_t;
endpackage

// ==== rtl/blink_divider.sv ====
// Purpose: one-cycle tick every HALF_CYCLES mclk cycles
// Assumes: clear is synchronous to mclk
// Notes: tick is registered; counting restarts from zero while clear is high
`timescale 1ns/1ps
module blink_divider #(
  parameter int HALF_CYCLES = reset_pin_pkg::BLINK_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  output logic tick
);
  typedef struct packed {
    logic [reset_pin_pkg::BLINK_CNT_W-1:0] count;
    logic tick;
  } div_state_t;

  localparam logic [reset_pin_pkg::BLINK_CNT_W-1:0] LAST =
    reset_pin_pkg::BLINK_CNT_W'(HALF_CYCLES - 1);

  div_state_t s_q;
  div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'h0;
    if (clear) begin
      s_d.count = '0;
    end else if (s_q.count == LAST) begin
      s_d.count = '0;
      s_d.tick = 1'h1;
    end else begin
      s_d.count = s_q.count + reset_pin_pkg::BLINK_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ==== rtl/reset_pin_state_control.sv ====
// Purpose: defined pin states around reset: processor power-good, open-drain
//   general-purpose output, post-reset blink pin, resume-well ready level
// Assumes: all inputs asynchronous to mclk; external pull-ups on open-drain pins
// Notes: open-drain pins are value plus enable; enable high means pulled low
`timescale 1ns/1ps
module reset_pin_state_control #(
  parameter int BLINK_HALF_CYCLES = reset_pin_pkg::BLINK_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regulatorPowerGoodIn,
  input wire logic systemPowerOkIn,
  input wire logic mainBusResetN,
  input wire logic resumeWellResetN,
  output logic procPowerGoodOut,
  output logic procPowerGoodOe,
  output logic openDrainGpOut,
  output logic openDrainGpOe,
  output logic postResetBlinkPin,
  output logic resumeWellReady
);
  typedef struct packed {
    logic regSync1;
    logic regSync2;
    logic okSync1;
    logic okSync2;
    logic mainSync1;
    logic mainSync2;
    logic rsmSync1;
    logic rsmSync2;
    reset_pin_pkg::boot_t boot;
    logic pgOe;
    logic gpOe;
    logic blink;
    logic resumeReady;
    logic odLevel;
  } ctl_state_t;

  localparam ctl_state_t STATE_RST = '{
    regSync1: reset_pin_pkg::SYNC_RST,
    regSync2: reset_pin_pkg::SYNC_RST,
    okSync1: reset_pin_pkg::SYNC_RST,
    okSync2: reset_pin_pkg::SYNC_RST,
    mainSync1: reset_pin_pkg::SYNC_RST,
    mainSync2: reset_pin_pkg::SYNC_RST,
    rsmSync1: reset_pin_pkg::SYNC_RST,
    rsmSync2: reset_pin_pkg::SYNC_RST,
    boot: reset_pin_pkg::BOOT_HOLD,
    pgOe: reset_pin_pkg::PG_OE_RST,
    gpOe: reset_pin_pkg::GP_OE_RST,
    blink: reset_pin_pkg::BLINK_RST,
    resumeReady: reset_pin_pkg::RESUME_READY_RST,
    odLevel: reset_pin_pkg::OD_DRIVE_LEVEL
  };

  ctl_state_t s_q;
  ctl_state_t s_d;
  logic blinkTick;
  logic mainRun;
  logic powerGood;

  // one lost input is enough to pull the processor power-good low
  function automatic logic bothValid(input logic regOk, input logic sysOk);
    return regOk && sysOk;
  endfunction

  // synchronised levels only; first stages feed nothing but the second
  assign mainRun = s_q.mainSync2;
  assign powerGood = bothValid(s_q.regSync2, s_q.okSync2);

  // divider restarts while main reset is held, so the first half period is full
  blink_divider #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink_div (
    .mclk(mclk),
    .rst(rst),
    .clear(!mainRun),
    .tick(blinkTick)
  );

  always_comb begin
    s_d = s_q;
    s_d.regSync1 = regulatorPowerGoodIn;
    s_d.regSync2 = s_q.regSync1;
    s_d.okSync1 = systemPowerOkIn;
    s_d.okSync2 = s_q.okSync1;
    s_d.mainSync1 = mainBusResetN;
    s_d.mainSync2 = s_q.mainSync1;
    s_d.rsmSync1 = resumeWellResetN;
    s_d.rsmSync2 = s_q.rsmSync1;

    // registered rather than combinational: costs 1 cycle, avoids glitches
    s_d.pgOe = !powerGood;

    unique case (s_q.boot)
      reset_pin_pkg::BOOT_HOLD: begin
        if (mainRun && powerGood) begin
          s_d.boot = reset_pin_pkg::BOOT_RUN;
        end
      end
      reset_pin_pkg::BOOT_RUN: begin
        // power loss counts as a hard reset with power cycling
        if (!mainRun || !powerGood) begin
          s_d.boot = reset_pin_pkg::BOOT_HOLD;
        end
      end
    endcase
    s_d.gpOe = (s_d.boot == reset_pin_pkg::BOOT_HOLD);

    if (!mainRun) begin
      s_d.blink = reset_pin_pkg::BLINK_RST;
    end else if (blinkTick) begin
      s_d.blink = !s_q.blink;
    end

    s_d.resumeReady = s_q.rsmSync2;
    s_d.odLevel = reset_pin_pkg::OD_DRIVE_LEVEL;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign procPowerGoodOut = s_q.odLevel;
  assign procPowerGoodOe = s_q.pgOe;
  assign openDrainGpOut = s_q.odLevel;
  assign openDrainGpOe = s_q.gpOe;
  assign postResetBlinkPin = s_q.blink;
  assign resumeWellReady = s_q.resumeReady;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_PG_LOW_WHEN_BAD: assert property (
    !(s_q.regSync2 && s_q.okSync2) |=> procPowerGoodOe)
    else $error("power-good not pulled low with an input inactive");

  AST_PG_RELEASE: assert property (
    (s_q.regSync2 && s_q.okSync2) |=> !procPowerGoodOe)
    else $error("power-good not released with both inputs valid");

  AST_PG_OPEN_DRAIN: assert property (
    procPowerGoodOut == 1'h0)
    else $error("power-good output drives a high level");

  AST_GP_OPEN_DRAIN: assert property (
    openDrainGpOut == 1'h0)
    else $error("open-drain output drives a high level");

  AST_GP_HOLD_LOW: assert property (
    (!s_q.mainSync2 || !(s_q.regSync2 && s_q.okSync2)) |=> openDrainGpOe)
    else $error("open-drain output released too early");

  AST_BLINK_IN_RESET: assert property (
    !s_q.mainSync2 |=> (postResetBlinkPin && !blinkTick))
    else $error("blink pin not high during main reset");

  AST_BLINK_TOGGLE: assert property (
    s_q.mainSync2 |=>
      (postResetBlinkPin != $past(postResetBlinkPin)) == $past(blinkTick))
    else $error("blink pin changed off tick or missed a tick");

  AST_RESUME_FOLLOW: assert property (
    resumeWellResetN [*3] |=> resumeWellReady)
    else $error("resume-well pin not released after resume reset");

  AST_SYNC_LATENCY: assert property (
    (regulatorPowerGoodIn && systemPowerOkIn) [*3] |=> !procPowerGoodOe)
    else $error("power-good release not within synchroniser latency");

  // raw pin views: three samples span both synchroniser stages
  AST_PG_DROP_REG: assert property (
    (!regulatorPowerGoodIn) [*3] |=> procPowerGoodOe)
    else $error("power-good not pulled low after regulator loss");

  AST_PG_DROP_OK: assert property (
    (!systemPowerOkIn) [*3] |=> procPowerGoodOe)
    else $error("power-good not pulled low after supply loss");

  AST_GP_MAIN_RESET: assert property (
    (!mainBusResetN) [*3] |=> openDrainGpOe)
    else $error("open-drain output not held low during main reset");

  AST_BLINK_MAIN_RESET: assert property (
    (!mainBusResetN) [*3] |=> postResetBlinkPin)
    else $error("blink pin not at reset level during main reset");

  AST_RESUME_HOLD: assert property (
    (!resumeWellResetN) [*3] |=> !resumeWellReady)
    else $error("resume-well pin not at reset level during resume reset");

  AST_GP_RELEASE: assert property (
    (s_q.mainSync2 && powerGood && s_q.boot == reset_pin_pkg::BOOT_HOLD) |=>
      !openDrainGpOe)
    else $error("open-drain output not released once ready");

  AST_GP_NO_EARLY: assert property (
    $fell(openDrainGpOe) |-> ($past(s_q.mainSync2) && $past(powerGood)))
    else $error("open-drain output released without main run and power good");

  AST_GP_RELEASE_LATENCY: assert property (
    (mainBusResetN && regulatorPowerGoodIn && systemPowerOkIn) [*3] |=>
      !openDrainGpOe)
    else $error("open-drain release not within synchroniser latency");

  CVR_PG_RELEASED: cover property ($fell(procPowerGoodOe));
  CVR_GP_RELEASED: cover property ($fell(openDrainGpOe));
  CVR_BLINK_TOGGLE: cover property (s_q.mainSync2 && $fell(postResetBlinkPin));
  CVR_POWER_CYCLE: cover property ($rose(openDrainGpOe) && s_q.mainSync2);
  CVR_RESUME_DROP: cover property ($fell(resumeWellReady));
endmodule

// ==== verif/power_side_model.sv ====
// Purpose: regulator, supply and pull-ups on the far side
// Assumes: both open-drain pins carry an external pull-up
// Notes: a released pin reads high, never a stale value
`timescale 1ns/1ps
module power_side_model (
  input wire logic vrOn,
  input wire logic psOn,
  input wire logic pgOe,
  input wire logic pgOut,
  input wire logic gpOe,
  input wire logic gpOut,
  output logic regPg,
  output logic sysOk,
  output logic pgPin,
  output logic gpPin
);
  assign regPg = vrOn;
  assign sysOk = psOn;
  // pull-up sets the level whenever enable is low
  assign pgPin = pgOe ? pgOut : 1'h1;
  assign gpPin = gpOe ? gpOut : 1'h1;
endmodule

// ==== verif/tb.sv ====
// Purpose: pin states around reset, power-good and blink
// Assumes: blink half period shortened to 8 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module tb;
  localparam int HALF = 8;
  logic mclk, rst, vrOn, psOn, mainN, resN, regPg, sysOk;
  logic pgOut, pgOe, gpOut, gpOe, blink, ready, pgPin, gpPin;
  int miscompares = 0;
  int checks = 0;
  reset_pin_state_control #(.BLINK_HALF_CYCLES(HALF)) dut (
    .mclk(mclk), .rst(rst), .regulatorPowerGoodIn(regPg),
    .systemPowerOkIn(sysOk), .mainBusResetN(mainN), .resumeWellResetN(resN),
    .procPowerGoodOut(pgOut), .procPowerGoodOe(pgOe), .openDrainGpOut(gpOut),
    .openDrainGpOe(gpOe), .postResetBlinkPin(blink), .resumeWellReady(ready));
  power_side_model far (
    .vrOn(vrOn), .psOn(psOn), .pgOe(pgOe), .pgOut(pgOut), .gpOe(gpOe),
    .gpOut(gpOut), .regPg(regPg), .sysOk(sysOk), .pgPin(pgPin), .gpPin(gpPin));
  task automatic test_done();
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic resume_run();
    resN = 1'h1;
    step(2);
    chk("ready early", 1'h0, ready);
    step(1);
    chk("ready", 1'h1, ready);
  endtask
  task automatic blink_run();
    int n;
    chk("blink held", 1'h1, blink);
    mainN = 1'h1;
    n = 0;
    while (blink === 1'h1 && n < 40) begin
      step(1);
      n++;
    end
    // first toggle only roughly placed, so a small window
    chk("first toggle", 1'h1, n >= HALF && n <= HALF + 4);
    n = 0;
    while (blink === 1'h0 && n < 40) begin
      step(1);
      n++;
    end
    chk("half period", 1'h1, n == HALF);
  endtask
  task automatic pg_run();
    logic [1:0] seq [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
    logic old;
    foreach (seq[i]) begin
      old = vrOn & psOn;
      {vrOn, psOn} = seq[i];
      step(2);
      chk("pgPin early", old, pgPin);
      step(1);
      chk("pgPin", &seq[i], pgPin);
      chk("pgOut", 1'h0, pgOut);
      chk("gpPin", &seq[i], gpPin);
      chk("gpOut", 1'h0, gpOut);
    end
  endtask
  task automatic main_again();
    mainN = 1'h0;
    step(3);
    chk("gp held again", 1'h0, gpPin);
    chk("blink again", 1'h1, blink);
  endtask
  // resume reset in mid-run: pin drops after both sync stages, then recovers
  task automatic resume_again();
    resN = 1'h0;
    step(2);
    chk("ready held", 1'h1, ready);
    step(1);
    chk("ready dropped", 1'h0, ready);
    resume_run();
  endtask
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // whole run is near 70 cycles; far margin before giving up
  initial begin
    #(3000 * 100);
    miscompares++;
    test_done();
  end
  initial begin
    {rst, vrOn, psOn, mainN, resN} = 5'h10;
    step(20);
    chk("pg in reset", 1'h0, pgPin);
    chk("gp in reset", 1'h0, gpPin);
    chk("ready in reset", 1'h0, ready);
    rst = 1'h0;
    resume_run();
    blink_run();
    pg_run();
    main_again();
    resume_again();
    test_done();
  end
endmodule
